// File: verilog/asp_consts.svh
`ifndef ASP_CONSTS_SVH
`define ASP_CONSTS_SVH

// ----------------------------------------------------------------
// serial word layout
// ----------------------------------------------------------------
`define ASP_WORD_BITS      16
`define ASP_WORD_MSB       15
`define ASP_LAST_BIT       4'hF
`define ASP_CTRL_FLAG_BIT  15
`define ASP_CTRL_READ_BIT  14
`define ASP_ADDR_MSB       10
`define ASP_ADDR_LSB       8
`define ASP_DATA_MSB       7
`define ASP_DATA_LSB       0

// ----------------------------------------------------------------
// control registers
// ----------------------------------------------------------------
`define ASP_NUM_REGS       5
`define ASP_NUM_REGS_ADDR  3'h5
`define ASP_REG_B          3'h1
`define ASP_REG_C          3'h2
`define ASP_REG_RST        8'h00
`define ASP_REFSEL_BIT     7
`define ASP_MDIV_MSB       2
`define ASP_MDIV_LSB       0
`define ASP_SDIV_MSB       5
`define ASP_SDIV_LSB       4

`endif

// File: verilog/asp_pkg.sv
package asp_pkg;

  typedef logic [15:0] asp_word_t;
  typedef logic [7:0]  asp_reg_t;
  typedef logic [2:0]  asp_addr_t;

  // gray order: idle -> sync -> shift
  typedef enum logic [1:0] {
    ASP_TX_IDLE  = 2'h0,
    ASP_TX_SYNC  = 2'h1,
    ASP_TX_SHIFT = 2'h3
  } asp_tx_state_e;

  typedef enum logic {
    ASP_RX_IDLE  = 1'h0,
    ASP_RX_SHIFT = 1'h1
  } asp_rx_state_e;

endpackage

// File: verilog/asp_clk_if.sv
`timescale 1ns/1ps

interface asp_clk_if;
  logic       run;
  logic [2:0] mdiv;
  logic [1:0] sdiv;
  logic       sclk;
  logic       rise;
  logic       fall;

  modport src (input run, input mdiv, input sdiv, output sclk, output rise, output fall);
  modport dst (output run, output mdiv, output sdiv, input sclk, input rise, input fall);
endinterface

// File: verilog/asp_clkdiv.sv
`timescale 1ns/1ps

module asp_clkdiv (
  input wire logic core_clk,
  input wire logic rst_n,
  asp_clk_if.src   clk_bus
);

  logic [2:0] pre_cnt_ff;
  logic [1:0] ser_cnt_ff;
  logic       sclk_ff;
  logic       dm_tick;
  logic       half_tick;

  // ----------------------------------------------------------------
  // master divider then serial divider
  // ----------------------------------------------------------------
  assign dm_tick   = (pre_cnt_ff == clk_bus.mdiv);
  assign half_tick = dm_tick && (ser_cnt_ff == clk_bus.sdiv);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_cnt_ff <= 3'h0;
    end else if (!clk_bus.run || dm_tick) begin
      pre_cnt_ff <= 3'h0;
    end else begin
      pre_cnt_ff <= pre_cnt_ff + 3'h1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ser_cnt_ff <= 2'h0;
    end else if (!clk_bus.run || half_tick) begin
      ser_cnt_ff <= 2'h0;
    end else if (dm_tick) begin
      ser_cnt_ff <= ser_cnt_ff + 2'h1;
    end
  end

  // stopped clock rests low so the first edge after enable is a rise
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_ff <= 1'h0;
    end else if (!clk_bus.run) begin
      sclk_ff <= 1'h0;
    end else if (half_tick) begin
      sclk_ff <= ~sclk_ff;
    end
  end

  assign clk_bus.sclk = sclk_ff;
  assign clk_bus.rise = clk_bus.run && half_tick && !sclk_ff;
  assign clk_bus.fall = clk_bus.run && half_tick && sclk_ff;

endmodule // asp_clkdiv

// File: verilog/asp_serial_port.sv
// Operation
// - reset clears registers and all logic
// - serial clock is master clock over dividers
// - data out changes on rising clock
// - data out tristated when idle or disabled
// - one-period frame sync before each word
// - frame sync out tristated when disabled
// - input frame sync sampled on falling edge
// - input bits captured on falling edge
// - inputs ignored while port disabled
// - disable tristates outputs, stops clock
// - registers kept, counters restart after disable
// - control C bit 7 picks reference
// - bit 7 is register msb
`timescale 1ns/1ps
`include "asp_consts.svh"

module asp_serial_port (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        port_enable,
  input  wire logic        serial_data_in,
  input  wire logic        input_frame_sync,
  output wire logic        serial_clk_out,
  output wire logic        serial_clk_oe,
  output wire logic        serial_data_out,
  output wire logic        serial_data_out_oe,
  output wire logic        output_frame_sync,
  output wire logic        output_frame_sync_oe,
  input  wire logic [15:0] conv_word,
  input  wire logic        conv_valid,
  output wire logic        conv_ready,
  output wire logic [15:0] rx_word,
  output wire logic        rx_valid,
  output wire logic        high_reference_select
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  asp_clk_if clk_bus ();

  asp_pkg::asp_reg_t      ctrl_reg_ff [`ASP_NUM_REGS];
  asp_pkg::asp_tx_state_e tx_state_ff;
  asp_pkg::asp_tx_state_e nxt_tx_state;
  asp_pkg::asp_rx_state_e rx_state_ff;
  asp_pkg::asp_word_t     tx_shift_ff;
  asp_pkg::asp_word_t     rx_shift_ff;
  asp_pkg::asp_word_t     rx_done_word_ff;
  asp_pkg::asp_word_t     rx_word_ff;
  asp_pkg::asp_word_t     rd_word_ff;
  asp_pkg::asp_word_t     load_word;
  asp_pkg::asp_addr_t     done_addr;
  logic [3:0]             tx_bit_ff;
  logic [3:0]             rx_bit_ff;
  logic                   sdo_ff;
  logic                   sdo_drive_ff;
  logic                   fs_ff;
  logic                   rx_done_ff;
  logic                   rx_valid_ff;
  logic                   rd_pend_ff;
  logic                   load_slot;
  logic                   load_any;
  logic                   rd_take;
  logic                   rd_set;
  logic                   done_is_ctrl;
  logic                   done_is_read;

  // ----------------------------------------------------------------
  // clock generation
  // ----------------------------------------------------------------
  // dividers come from control register B so software sets the rate
  assign clk_bus.run  = port_enable;
  assign clk_bus.mdiv = ctrl_reg_ff[`ASP_REG_B][`ASP_MDIV_MSB:`ASP_MDIV_LSB];
  assign clk_bus.sdiv = ctrl_reg_ff[`ASP_REG_B][`ASP_SDIV_MSB:`ASP_SDIV_LSB];

  asp_clkdiv u_clkdiv (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clk_bus  (clk_bus)
  );

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  // enables are gated by the raw pin so a disable tristates at once
  assign serial_clk_out       = clk_bus.sclk;
  assign serial_clk_oe        = port_enable;
  assign serial_data_out      = sdo_ff;
  assign serial_data_out_oe   = port_enable && sdo_drive_ff;
  assign output_frame_sync    = fs_ff;
  assign output_frame_sync_oe = port_enable;
  assign rx_word              = rx_word_ff;
  assign rx_valid             = rx_valid_ff;
  assign high_reference_select = ctrl_reg_ff[`ASP_REG_C][`ASP_REFSEL_BIT];

  // ----------------------------------------------------------------
  // transmit source selection
  // ----------------------------------------------------------------
  // a word is loaded only on a rising edge, from idle or after the last bit
  assign load_slot = clk_bus.rise &&
                     ((tx_state_ff == asp_pkg::ASP_TX_IDLE) ||
                      ((tx_state_ff == asp_pkg::ASP_TX_SHIFT) && (tx_bit_ff == `ASP_LAST_BIT)));
  // register read-back wins over conversion data
  assign rd_take    = load_slot && rd_pend_ff;
  assign conv_ready = load_slot && !rd_pend_ff;
  assign load_any   = rd_take || (conv_ready && conv_valid);
  assign load_word  = rd_pend_ff ? rd_word_ff : conv_word;

  always_comb begin
    nxt_tx_state = tx_state_ff;
    case (tx_state_ff)
      asp_pkg::ASP_TX_IDLE: begin
        if (load_any) begin
          nxt_tx_state = asp_pkg::ASP_TX_SYNC;
        end
      end
      asp_pkg::ASP_TX_SYNC: begin
        if (clk_bus.rise) begin
          nxt_tx_state = asp_pkg::ASP_TX_SHIFT;
        end
      end
      asp_pkg::ASP_TX_SHIFT: begin
        if (load_slot) begin
          nxt_tx_state = load_any ? asp_pkg::ASP_TX_SYNC : asp_pkg::ASP_TX_IDLE;
        end
      end
      default: begin
        nxt_tx_state = asp_pkg::ASP_TX_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // transmit state
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_state_ff <= asp_pkg::ASP_TX_IDLE;
    end else if (!port_enable) begin
      tx_state_ff <= asp_pkg::ASP_TX_IDLE;
    end else begin
      tx_state_ff <= nxt_tx_state;
    end
  end

  // frame sync is high for exactly the period before the msb
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fs_ff <= 1'h0;
    end else if (!port_enable) begin
      fs_ff <= 1'h0;
    end else if (clk_bus.rise) begin
      fs_ff <= load_any;
    end
  end

  // data pin drives only during the sixteen bit periods
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sdo_drive_ff <= 1'h0;
    end else if (!port_enable) begin
      sdo_drive_ff <= 1'h0;
    end else if (clk_bus.rise) begin
      sdo_drive_ff <= (tx_state_ff == asp_pkg::ASP_TX_SYNC) ||
                      ((tx_state_ff == asp_pkg::ASP_TX_SHIFT) && (tx_bit_ff != `ASP_LAST_BIT));
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_shift_ff <= 16'h0000;
      sdo_ff      <= 1'h0;
    end else if (!port_enable) begin
      tx_shift_ff <= 16'h0000;
      sdo_ff      <= 1'h0;
    end else if (clk_bus.rise) begin
      if (load_any) begin
        tx_shift_ff <= load_word;
      end else if (tx_state_ff != asp_pkg::ASP_TX_IDLE) begin
        sdo_ff      <= tx_shift_ff[`ASP_WORD_MSB];
        tx_shift_ff <= {tx_shift_ff[14:0], 1'h0};
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_bit_ff <= 4'h0;
    end else if (!port_enable) begin
      tx_bit_ff <= 4'h0;
    end else if (clk_bus.rise) begin
      if (tx_state_ff == asp_pkg::ASP_TX_SHIFT) begin
        tx_bit_ff <= tx_bit_ff + 4'h1;
      end else begin
        tx_bit_ff <= 4'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // receive path
  // ----------------------------------------------------------------
  // falls never occur while disabled, so the pins are not looked at
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_state_ff <= asp_pkg::ASP_RX_IDLE;
      rx_bit_ff   <= 4'h0;
    end else if (!port_enable) begin
      rx_state_ff <= asp_pkg::ASP_RX_IDLE;
      rx_bit_ff   <= 4'h0;
    end else if (clk_bus.fall) begin
      case (rx_state_ff)
        asp_pkg::ASP_RX_IDLE: begin
          if (input_frame_sync) begin
            rx_state_ff <= asp_pkg::ASP_RX_SHIFT;
          end
          rx_bit_ff <= 4'h0;
        end
        asp_pkg::ASP_RX_SHIFT: begin
          rx_bit_ff <= rx_bit_ff + 4'h1;
          // a sync in the last bit period starts the next word back to back
          if ((rx_bit_ff == `ASP_LAST_BIT) && !input_frame_sync) begin
            rx_state_ff <= asp_pkg::ASP_RX_IDLE;
          end
        end
        default: begin
          rx_state_ff <= asp_pkg::ASP_RX_IDLE;
          rx_bit_ff   <= 4'h0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_shift_ff <= 16'h0000;
    end else if (!port_enable) begin
      rx_shift_ff <= 16'h0000;
    end else if (clk_bus.fall && (rx_state_ff == asp_pkg::ASP_RX_SHIFT)) begin
      rx_shift_ff <= {rx_shift_ff[14:0], serial_data_in};
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_done_ff      <= 1'h0;
      rx_done_word_ff <= 16'h0000;
    end else if (!port_enable) begin
      rx_done_ff      <= 1'h0;
      rx_done_word_ff <= 16'h0000;
    end else begin
      rx_done_ff <= clk_bus.fall && (rx_state_ff == asp_pkg::ASP_RX_SHIFT) && (rx_bit_ff == `ASP_LAST_BIT);
      if (clk_bus.fall && (rx_state_ff == asp_pkg::ASP_RX_SHIFT) && (rx_bit_ff == `ASP_LAST_BIT)) begin
        rx_done_word_ff <= {rx_shift_ff[14:0], serial_data_in};
      end
    end
  end

  // ----------------------------------------------------------------
  // word decode
  // ----------------------------------------------------------------
  assign done_is_ctrl = rx_done_ff && rx_done_word_ff[`ASP_CTRL_FLAG_BIT];
  assign done_is_read = done_is_ctrl && rx_done_word_ff[`ASP_CTRL_READ_BIT];
  assign done_addr    = rx_done_word_ff[`ASP_ADDR_MSB:`ASP_ADDR_LSB];
  assign rd_set       = done_is_read;

  // data words go to the user side; control words stay inside
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_valid_ff <= 1'h0;
      rx_word_ff  <= 16'h0000;
    end else begin
      rx_valid_ff <= rx_done_ff && !rx_done_word_ff[`ASP_CTRL_FLAG_BIT];
      if (rx_done_ff && !rx_done_word_ff[`ASP_CTRL_FLAG_BIT]) begin
        rx_word_ff <= rx_done_word_ff;
      end
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  // port disable does not touch them; only the reset pin does
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `ASP_NUM_REGS; i++) begin
        ctrl_reg_ff[i] <= `ASP_REG_RST;
      end
    end else if (done_is_ctrl && !done_is_read && (done_addr < `ASP_NUM_REGS_ADDR)) begin
      ctrl_reg_ff[done_addr] <= rx_done_word_ff[`ASP_DATA_MSB:`ASP_DATA_LSB];
    end
  end

  // read-back word: control flag, read flag, address, register value
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_word_ff <= 16'h0000;
    end else if (rd_set) begin
      rd_word_ff <= {rx_done_word_ff[15:8],
                     (done_addr < `ASP_NUM_REGS_ADDR) ? ctrl_reg_ff[done_addr] : 8'h00};
    end
  end

  // a new request beats the clear of the one being sent
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_pend_ff <= 1'h0;
    end else if (!port_enable) begin
      rd_pend_ff <= 1'h0;
    end else if (rd_set) begin
      rd_pend_ff <= 1'h1;
    end else if (rd_take) begin
      rd_pend_ff <= 1'h0;
    end
  end

endmodule // asp_serial_port

// File: testbench/asp_serial_port_monitor.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// pin checker
// ------------------------------------------------------------
module asp_serial_port_monitor (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic port_enable,
  input wire logic serial_clk_out,
  input wire logic serial_clk_oe,
  input wire logic serial_data_out,
  input wire logic serial_data_out_oe,
  input wire logic output_frame_sync,
  input wire logic output_frame_sync_oe,
  input wire logic conv_valid,
  input wire logic conv_ready,
  input wire logic rx_valid
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic       sclk_q_ff;
  logic [4:0] cnt_ff;
  wire logic  rise = serial_clk_out && !sclk_q_ff;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) sclk_q_ff <= 1'h0;
    else sclk_q_ff <= serial_clk_out;
  end
  // rises since frame sync; parks at 1F outside words so idle rises mean nothing
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) cnt_ff <= 5'h1F;
    else if (!port_enable) cnt_ff <= 5'h1F;
    else if (output_frame_sync) cnt_ff <= 5'h00;
    else if (rise && cnt_ff != 5'h1F) cnt_ff <= cnt_ff + 5'h01;
  end
  a_clk_oe_enable: assert property (serial_clk_oe == port_enable)
    else $error("serial clock enable differs from port enable");
  a_fs_oe_enable: assert property (output_frame_sync_oe == port_enable)
    else $error("frame sync enable differs from port enable");
  a_sdo_oe_off: assert property (!port_enable |-> !serial_data_out_oe)
    else $error("data out driven while disabled");
  a_sclk_stopped: assert property (!port_enable [*2] |-> !serial_clk_out)
    else $error("serial clock runs while disabled");
  a_sdo_on_rise: assert property (port_enable && serial_data_out_oe && $past(serial_data_out_oe)
    && $changed(serial_data_out) |-> rise) else $error("data out changed off a rising edge");
  a_fs_on_rise: assert property (port_enable && $past(port_enable) && $changed(output_frame_sync)
    |-> rise) else $error("frame sync changed off a rising edge");
  a_fs_one_period: assert property (port_enable && rise && output_frame_sync
    |-> !$past(output_frame_sync)) else $error("frame sync longer than one period");
  a_bits_driven: assert property (port_enable && rise && !output_frame_sync && cnt_ff <= 5'h0F
    |-> serial_data_out_oe) else $error("data out released inside a word");
  a_word_end: assert property (port_enable && rise && cnt_ff == 5'h10
    |-> !serial_data_out_oe || output_frame_sync) else $error("word not sixteen bits");
  a_take_fs: assert property (conv_valid && conv_ready |=> rise && output_frame_sync)
    else $error("taken word without frame sync");
  a_ready_off: assert property (!port_enable |-> !conv_ready)
    else $error("word taken while disabled");
  a_rx_pulse: assert property (rx_valid |=> !rx_valid)
    else $error("receive pulse too long");
endmodule // asp_serial_port_monitor

bind asp_serial_port asp_serial_port_monitor u_mon (.core_clk, .rst_n, .port_enable, .serial_clk_out,
  .serial_clk_oe, .serial_data_out, .serial_data_out_oe, .output_frame_sync, .output_frame_sync_oe,
  .conv_valid, .conv_ready, .rx_valid);

// File: testbench/asp_host_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// host side
// ------------------------------------------------------------
module asp_host_model (
  input  wire logic        serial_clk_out,
  input  wire logic        port_enable,
  input  wire logic        serial_data_out,
  input  wire logic        output_frame_sync,
  input  wire logic [15:0] h_word,
  input  wire logic        h_go,
  output logic             serial_data_in,
  output logic             input_frame_sync,
  output logic             h_busy,
  output logic [15:0]      got,
  output int               gotn
);
  logic [15:0] tsh = 16'h0000;
  logic [15:0] rsh = 16'h0000;
  int          tcnt = 0;
  int          rcnt = 0;
  initial begin
    serial_data_in = 1'h0;
    input_frame_sync = 1'h0;
    h_busy = 1'h0;
    got = 16'h0000;
    gotn = 0;
  end
  // drive on the rising edge so bits are settled at the device's falling edge
  always @(posedge serial_clk_out or negedge port_enable) begin
    if (!port_enable) begin
      tcnt = 0;
      input_frame_sync <= 1'h0;
    end else if (tcnt > 0) begin
      input_frame_sync <= 1'h0;
      serial_data_in <= tsh[15];
      tsh = tsh << 1;
      tcnt = tcnt - 1;
    end else if (h_go) begin
      input_frame_sync <= 1'h1;
      tsh = h_word;
      tcnt = 16;
    end else begin
      serial_data_in <= ~serial_data_in; // released: never rests on the last bit
    end
    // busy from the sync period until the rising edge that drives the last bit
    h_busy = tcnt > 0;
  end
  always @(negedge serial_clk_out or negedge port_enable) begin
    if (!port_enable) rcnt = 0;
    else if (rcnt > 0) begin
      rsh = {rsh[14:0], serial_data_out};
      rcnt = rcnt - 1;
      if (rcnt == 0) begin
        got = rsh;
        gotn = gotn + 1;
      end
    end else if (output_frame_sync) rcnt = 16;
  end
endmodule // asp_host_model

// File: testbench/tb_asp_serial_port.sv
`timescale 1ns/1ps
module tb_asp_serial_port;
  logic             core_clk = 1'h0;
  logic             rst_n = 1'h0;
  logic             port_enable = 1'h1;
  logic [15:0]      conv_word = 16'h0000;
  logic             conv_valid = 1'h0;
  logic [15:0]      h_word = 16'h0000;
  logic             h_go = 1'h0;
  logic [15:0]      rxw = 16'h0000;
  int               rxn = 0;
  int               gotn;
  int               miscompares = 0;
  int               total_checks = 0;
  wire logic        serial_clk_out, serial_clk_oe, serial_data_out, serial_data_out_oe;
  wire logic        output_frame_sync, output_frame_sync_oe, serial_data_in, input_frame_sync;
  wire logic        conv_ready, rx_valid, high_reference_select, h_busy;
  wire logic [15:0] rx_word, got;
  asp_serial_port dut (.core_clk, .rst_n, .port_enable, .serial_data_in, .input_frame_sync,
    .serial_clk_out, .serial_clk_oe, .serial_data_out, .serial_data_out_oe, .output_frame_sync,
    .output_frame_sync_oe, .conv_word, .conv_valid, .conv_ready, .rx_word, .rx_valid,
    .high_reference_select);
  asp_host_model host (.serial_clk_out, .port_enable, .serial_data_out, .output_frame_sync, .h_word,
    .h_go, .serial_data_in, .input_frame_sync, .h_busy, .got, .gotn);
  always #25 core_clk = ~core_clk;
  always @(posedge core_clk) if (rx_valid === 1'h1) begin
    rxw <= rx_word;
    rxn <= rxn + 1;
  end
  // ------------------------------------------------------------
  // checking
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #(20000 * 50);
    miscompares++;
    end_of_test();
  end
  // ------------------------------------------------------------
  // drivers
  // ------------------------------------------------------------
  task automatic tx(input logic [15:0] w, input bit hold);
    int n;
    conv_word <= w;
    conv_valid <= 1'h1;
    n = 0;
    do begin @(negedge core_clk); n++; end while (conv_ready !== 1'h1 && n < 500);
    chk("ready wait", {15'h0, conv_ready}, 16'h0001);
    @(posedge core_clk);
    if (!hold) conv_valid <= 1'h0;
  endtask
  task automatic host_start(input logic [15:0] w);
    int n;
    h_word <= w;
    h_go <= 1'h1;
    n = 0;
    do begin @(posedge core_clk); n++; end while (h_busy !== 1'h1 && n < 500);
    chk("host start", {15'h0, h_busy}, 16'h0001);
    h_go <= 1'h0;
  endtask
  task automatic host_send(input logic [15:0] w);
    int n;
    host_start(w);
    n = 0;
    while (h_busy === 1'h1 && n < 2000) begin @(posedge core_clk); n++; end
    chk("host done", {15'h0, h_busy}, 16'h0000);
    @(negedge serial_clk_out);
    repeat (3) @(posedge core_clk);
  endtask
  task automatic want_tx(input int k, input logic [15:0] exp);
    int n;
    n = 0;
    while (gotn < k && n < 3000) begin @(posedge core_clk); n++; end
    chk("host count", 16'(gotn), 16'(k));
    chk("host word", got, exp);
  endtask
  task automatic period(input logic [15:0] exp);
    time t0;
    @(posedge serial_clk_out);
    t0 = $time;
    @(posedge serial_clk_out);
    chk("sclk period", 16'(($time - t0) / 50), exp);
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    chk("refsel", {15'h0, high_reference_select}, 16'h0000);
    chk("sdo oe", {15'h0, serial_data_out_oe}, 16'h0000);
    period(16'h0002);
  endtask
  task automatic t_tx();
    tx(16'hA5C3, 1'b1);
    tx(16'h8001, 1'b0);
    want_tx(1, 16'hA5C3);
    want_tx(2, 16'h8001);
  endtask
  task automatic t_rx();
    host_send(16'h3C96);
    chk("rx count", 16'(rxn), 16'h0001);
    chk("rx word", rxw, 16'h3C96);
  endtask
  task automatic t_ctrl();
    host_send(16'h8280);
    chk("refsel", {15'h0, high_reference_select}, 16'h0001);
    host_send(16'h8201);
    chk("refsel", {15'h0, high_reference_select}, 16'h0000);
    host_send(16'h8280);
    host_send(16'h8111);
    period(16'h0008);
    host_send(16'hC200);
    want_tx(3, 16'hC280);
    host_send(16'hC500);
    want_tx(4, 16'hC500);
    chk("rx count", 16'(rxn), 16'h0001);
  endtask
  task automatic t_disable();
    host_start(16'h1111);
    repeat (5) @(posedge serial_clk_out);
    @(posedge core_clk);
    port_enable <= 1'h0;
    repeat (3) @(posedge core_clk);
    chk("oes", {13'h0, serial_clk_oe, serial_data_out_oe, output_frame_sync_oe}, 16'h0000);
    repeat (20) @(posedge core_clk);
    chk("sclk", {15'h0, serial_clk_out}, 16'h0000);
    port_enable <= 1'h1;
    period(16'h0008);
    repeat (40) @(posedge serial_clk_out);
    chk("rx count", 16'(rxn), 16'h0001);
    chk("refsel", {15'h0, high_reference_select}, 16'h0001);
  endtask
  // reset in mid-run must drop the divider and reference settings again
  task automatic t_reset_mid();
    @(posedge core_clk);
    rst_n <= 1'h0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'h1;
    @(posedge core_clk);
    chk("refsel", {15'h0, high_reference_select}, 16'h0000);
    period(16'h0002);
  endtask
  initial begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'h1;
    @(posedge core_clk);
    t_reset();
    t_tx();
    t_rx();
    t_ctrl();
    t_disable();
    t_reset_mid();
    end_of_test();
  end
endmodule // tb_asp_serial_port
